// file: hdl/sdram_map_pkg.sv
// Purpose: Constants for the SDRAM address split and access latency model
// Assumes: AHB clock at 100 MHz, x16 parts with four banks
// Notes: Latencies are counted in bus clocks from the cycle a request is taken
package sdram_map_pkg;
  // Row width settings
  localparam logic [1:0] ROW_11 = 2'h0;
  localparam logic [1:0] ROW_12 = 2'h1;
  localparam logic [1:0] ROW_13 = 2'h2;
  // Column width settings
  localparam logic [1:0] COL_8 = 2'h0;
  localparam logic [1:0] COL_9 = 2'h1;
  localparam logic [1:0] COL_10 = 2'h2;
  localparam logic [1:0] COL_11 = 2'h3;
  // Base widths the settings add to
  localparam int ROW_BASE = 11;
  localparam int COL_BASE = 8;
  localparam int NUM_BANKS = 4;
  // Single read latency per page state
  localparam logic [3:0] RD_IDLE = 4'h8;
  localparam logic [3:0] RD_HIT = 4'h6;
  localparam logic [3:0] RD_MISS = 4'hb;
  // Single write latency, any page state
  localparam logic [3:0] WR_SINGLE = 4'h1;
  // First burst write beat per page state
  localparam logic [3:0] BW_IDLE = 4'h5;
  localparam logic [3:0] BW_HIT = 4'h3;
  localparam logic [3:0] BW_MISS = 4'h8;
  // Later beats of any burst
  localparam logic [3:0] BEAT_GAP = 4'h2;
  // Read right after a single write, same page
  localparam logic [3:0] RD_AFTER_WR = 4'h5;
  // Burst length codes
  localparam logic [1:0] LEN_1 = 2'h0;
  localparam logic [1:0] LEN_4 = 2'h1;
  localparam logic [1:0] LEN_8 = 2'h2;
endpackage

// file: hdl/sdram_fifo.sv
// Purpose: Small flip-flop FIFO for read data heading to the bus master
// Assumes: Single clock, synchronous push and pop
// Notes: Depth must be a power of two
`timescale 1ns/10ps
`default_nettype none
module sdram_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Storage and pointers, one extra bit tells full from empty
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  logic push;
  logic pop;

  assign in_ready = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
  assign out_valid = wr_ff != rd_ff;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ff[AW-1:0]];

  // Write side
  always_ff @(posedge core_clk)
  begin
    if (push)
      mem_ff[wr_ff[AW-1:0]] <= in_data;
  end

  // Pointers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ff <= wr_ff + 1'b1;
      if (pop)
        rd_ff <= rd_ff + 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: hdl/sdram_addr_map_and_latency.sv
// Purpose: Split bus addresses into bank, row, column and pace accesses
// Assumes: Inputs synchronous to core_clk; memory data is returned on mem_rdata
// Notes: Open-page state kept per bank; read beats pass through an 8-word FIFO
`timescale 1ns/10ps
`default_nettype none
module sdram_addr_map_and_latency #(
  parameter int AW = 27,
  parameter int DW = 32,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic bank_interleave_select,
  input wire logic [1:0] row_sel,
  input wire logic [1:0] col_sel,
  input wire logic refresh_req,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [1:0] req_len,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] mem_rdata,
  output logic [1:0] map_bank,
  output logic [12:0] map_row,
  output logic [10:0] map_col,
  output logic beat_done,
  output logic busy,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [DW-1:0] rd_data
);
  // ----------------------------------------
  // Address split
  // ----------------------------------------
  // Widths derived from the settings
  logic [3:0] row_w;
  logic [3:0] col_w;
  logic [1:0] bank_c;
  logic [12:0] row_c;
  logic [10:0] col_c;
  logic [AW-1:0] rest;

  assign row_w = 4'(sdram_map_pkg::ROW_BASE) + {2'h0, (row_sel == 2'h3) ? sdram_map_pkg::ROW_13 : row_sel};
  assign col_w = 4'(sdram_map_pkg::COL_BASE) + {2'h0, col_sel};

  // Field extraction, bank position follows widths in either mode
  always_comb
  begin
    col_c = 11'(req_addr & ((AW'(1) << col_w) - AW'(1)));
    rest = req_addr >> col_w;
    if (bank_interleave_select)
    begin
      bank_c = rest[1:0];
      row_c = 13'((rest >> 2) & ((AW'(1) << row_w) - AW'(1)));
    end
    else
    begin
      row_c = 13'(rest & ((AW'(1) << row_w) - AW'(1)));
      bank_c = 2'(rest >> row_w);
    end
  end

  // ----------------------------------------
  // Open page tracking
  // ----------------------------------------
  // rows stay open per bank
  logic [sdram_map_pkg::NUM_BANKS-1:0] open_ff;
  logic [12:0] open_row_ff [sdram_map_pkg::NUM_BANKS];
  logic take;
  logic hit;
  logic idle_bank;

  assign take = req_valid && req_ready;
  assign idle_bank = !open_ff[bank_c];
  assign hit = open_ff[bank_c] && (open_row_ff[bank_c] == row_c);

  genvar gb;
  generate
    for (gb = 0; gb < sdram_map_pkg::NUM_BANKS; gb++)
    begin : g_bank
      // open on access, close only on refresh; miss reopens new row
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          open_ff[gb] <= 1'b0;
          open_row_ff[gb] <= 13'h0;
        end
        else if (refresh_req)
          open_ff[gb] <= 1'b0;
        else if (take && bank_c == 2'(gb))
        begin
          open_ff[gb] <= 1'b1;
          open_row_ff[gb] <= row_c;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Latency sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_STALL = 3'h4
  } seq_e;
  seq_e state_ff;
  logic [3:0] cnt_ff;
  logic [3:0] beats_ff;
  logic wr_ff;
  logic last_single_ff;
  logic last_wr_ff;
  logic [1:0] last_bank_ff;
  logic [12:0] last_row_ff;
  logic fifo_ready;
  logic [3:0] first_lat;
  logic same_pg;

  assign same_pg = last_single_ff && last_bank_ff == bank_c && last_row_ff == row_c;
  assign req_ready = (state_ff == ST_IDLE) && !refresh_req;
  assign busy = state_ff != ST_IDLE;

  // First-beat latency from page state and previous access
  always_comb
  begin
    if (req_len == sdram_map_pkg::LEN_1 && req_write)
      first_lat = (same_pg && !last_wr_ff) ? sdram_map_pkg::BEAT_GAP : sdram_map_pkg::WR_SINGLE;
    else if (req_write)
      first_lat = hit ? sdram_map_pkg::BW_HIT : idle_bank ? sdram_map_pkg::BW_IDLE : sdram_map_pkg::BW_MISS;
    else if (req_len == sdram_map_pkg::LEN_1 && same_pg && last_wr_ff)
      first_lat = sdram_map_pkg::RD_AFTER_WR;
    else
      first_lat = hit ? sdram_map_pkg::RD_HIT : idle_bank ? sdram_map_pkg::RD_IDLE : sdram_map_pkg::RD_MISS;
  end

  // Beat counter: cnt_ff counts down to the beat's completion
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      beats_ff <= 4'h0;
      wr_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (take)
          begin
            state_ff <= ST_WAIT;
            cnt_ff <= first_lat - 4'h1;
            wr_ff <= req_write;
            beats_ff <= (req_len == sdram_map_pkg::LEN_8) ? 4'h7 : (req_len == sdram_map_pkg::LEN_4) ? 4'h3 : 4'h0;
          end
        end
        ST_WAIT:
        begin
          if (cnt_ff != 4'h0)
            cnt_ff <= cnt_ff - 4'h1;
          else if (!wr_ff && !fifo_ready)
            state_ff <= ST_STALL;
          else if (beats_ff != 4'h0)
          begin
            beats_ff <= beats_ff - 4'h1;
            cnt_ff <= sdram_map_pkg::BEAT_GAP - 4'h1;
          end
          else
            state_ff <= ST_IDLE;
        end
        ST_STALL:
        begin
          // Read data has nowhere to go; hold until the FIFO has a free slot
          if (fifo_ready)
            state_ff <= ST_WAIT;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // History for back-to-back pairs
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_single_ff <= 1'b0;
      last_wr_ff <= 1'b0;
      last_bank_ff <= 2'h0;
      last_row_ff <= 13'h0;
    end
    else if (refresh_req)
      last_single_ff <= 1'b0;
    else if (take)
    begin
      last_single_ff <= req_len == sdram_map_pkg::LEN_1;
      last_wr_ff <= req_write;
      last_bank_ff <= bank_c;
      last_row_ff <= row_c;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      map_bank <= 2'h0;
      map_row <= 13'h0;
      map_col <= 11'h0;
    end
    else if (take)
    begin
      map_bank <= bank_c;
      map_row <= row_c;
      map_col <= col_c;
    end
  end

  assign beat_done = (state_ff == ST_WAIT) && cnt_ff == 4'h0 && (wr_ff || fifo_ready);

  // ----------------------------------------
  // Read data buffer
  // ----------------------------------------
  sdram_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) sdram_fifo_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(beat_done && !wr_ff),
    .in_ready(fifo_ready),
    .in_data(mem_rdata),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_single_write_one: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && req_write && req_len == 2'h0 && !(same_pg && !last_wr_ff) |=> beat_done)
    else $error("single write not done in one clock");
  chk_read_idle_eight: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && !req_write && req_len == 2'h0 && idle_bank && !(same_pg && last_wr_ff) && fifo_ready
    |=> !beat_done [*7] ##1 (beat_done || !fifo_ready))
    else $error("idle read latency wrong");
  chk_beat_gap_two: assert property (@(posedge core_clk) disable iff (!rst_n)
    beat_done && beats_ff != 4'h0 && fifo_ready |=> !beat_done ##1 (beat_done || !fifo_ready))
    else $error("burst beat gap not two");
  chk_interleave_bank: assert property (@(posedge core_clk) disable iff (!rst_n)
    bank_interleave_select && row_sel == 2'h2 && col_sel == 2'h3 |-> bank_c == req_addr[12:11])
    else $error("interleaved bank field wrong");
  chk_linear_bank: assert property (@(posedge core_clk) disable iff (!rst_n)
    !bank_interleave_select && row_sel == 2'h2 && col_sel == 2'h3 |-> bank_c == req_addr[25:24])
    else $error("linear bank field wrong");
  chk_open_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && !refresh_req |=> open_ff[$past(bank_c)])
    else $error("row not left open");
  chk_refresh_close: assert property (@(posedge core_clk) disable iff (!rst_n)
    refresh_req |=> open_ff == 4'h0)
    else $error("refresh did not close banks");
  chk_rd_after_wr: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && !req_write && req_len == 2'h0 && same_pg && last_wr_ff
    |=> !beat_done [*4] ##1 (beat_done || !fifo_ready))
    else $error("read after write latency wrong");
  cov_burst8_read: cover property (@(posedge core_clk) take && !req_write && req_len == 2'h2);
  cov_page_hit: cover property (@(posedge core_clk) take && hit);
  cov_fifo_stall: cover property (@(posedge core_clk) state_ff == ST_STALL);
endmodule
`default_nettype wire

// file: verification/sdram_mem_model.sv
// Purpose: Stand-in for the x16 memory parts feeding read data
// Assumes: The block samples mem_rdata on each read beat_done
// Notes: Each word carries the beat index and the mapped fields
`timescale 1ns/10ps
`default_nettype none
module sdram_mem_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic take,
  input wire logic beat_done,
  input wire logic [1:0] map_bank,
  input wire logic [12:0] map_row,
  input wire logic [10:0] map_col,
  output logic [31:0] mem_rdata
);
  // Beat index inside the current access
  logic [3:0] beat_ff;
  logic [31:0] word;
  // -----------------------------
  // Beat counting
  // -----------------------------
  // Restarts on each take, advances per beat
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      beat_ff <= 4'h0;
    else if (take)
      beat_ff <= 4'h0;
    else if (beat_done)
      beat_ff <= beat_ff + 4'h1;
  assign word = {beat_ff, 2'h0, map_bank, map_row, map_col};
  // Off-beat the bus shows the inverse, so a stale sample never matches
  assign mem_rdata = beat_done ? word : ~word;
endmodule
`default_nettype wire

// file: verification/sdram_addr_map_and_latency_tb_top.sv
// Purpose: Self-checking bench for address split and access pacing
// Assumes: Inputs change on the falling edge
// Notes: Read data checked word by word through the FIFO
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module sdram_addr_map_and_latency_tb_top;
  logic core_clk = 1'b0;
  logic rst_n, bank_interleave_select, refresh_req, req_valid, req_write, rd_ready, stall;
  logic req_ready, beat_done, busy, rd_valid, take;
  logic [1:0] row_sel, col_sel, req_len, map_bank;
  logic [26:0] req_addr;
  logic [31:0] mem_rdata, rd_data, tmp, exp_word;
  logic [12:0] map_row;
  logic [10:0] map_col;
  // Bench view of open rows and the previous single access
  logic open_v [4];
  logic [12:0] open_row [4];
  logic [1:0] prev_b;
  logic [12:0] prev_r;
  int pk, seed, errors, comparisons, cycles;
  logic [31:0] expq [$];
  assign take = req_valid & req_ready;
  sdram_addr_map_and_latency sdram_addr_map_and_latency_inst (.core_clk(core_clk), .rst_n(rst_n),
    .bank_interleave_select(bank_interleave_select), .row_sel(row_sel), .col_sel(col_sel),
    .refresh_req(refresh_req), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_len(req_len), .req_addr(req_addr), .mem_rdata(mem_rdata), .map_bank(map_bank),
    .map_row(map_row), .map_col(map_col), .beat_done(beat_done), .busy(busy),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
  sdram_mem_model sdram_mem_model_inst (.core_clk(core_clk), .rst_n(rst_n), .take(take),
    .beat_done(beat_done), .map_bank(map_bank), .map_row(map_row), .map_col(map_col),
    .mem_rdata(mem_rdata));
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end
  // Hang guard, far above the few thousand cycles the tests need
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      complete_run();
    end
  end
  // Read side: drain with a fixed pattern unless stalled
  always @(negedge core_clk)
  begin
    rd_ready = stall ? 1'b0 : (cycles[0] ^ cycles[2]);
    if (rst_n && rd_valid && rd_ready)
    begin
      exp_word = (expq.size() != 0) ? expq.pop_front() : 32'h0;
      `CHK(rd_data, exp_word)
    end
  end
  task automatic complete_run;
    begin
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // One access: builds the address from fields, checks split and pacing
  task automatic access(input logic wr, input logic [1:0] len, input logic [1:0] b,
      input logic [12:0] r, input logic [10:0] c);
    int lat, n, rb, cb, beats;
    logic same;
    begin
      cb = 8 + int'(col_sel);
      rb = (row_sel == 2'h0) ? 11 : (row_sel == 2'h1) ? 12 : 13;
      r = r & 13'((1 << rb) - 1);
      c = c & 11'((1 << cb) - 1);
      n = 0;
      // Reads wait for an empty FIFO so a full buffer cannot skew pacing
      while (!wr && expq.size() != 0 && n < 300)
      begin
        @(negedge core_clk);
        n++;
      end
      if (n == 300)
        errors++;
      same = (prev_b == b) && (prev_r == r);
      if (wr && len == 2'h0)
        lat = (pk == 1 && same) ? 2 : 1;
      else if (len == 2'h0 && pk == 2 && same)
        lat = 5;
      else if (wr)
        lat = !open_v[b] ? 5 : (open_row[b] == r) ? 3 : 8;
      else
        lat = !open_v[b] ? 8 : (open_row[b] == r) ? 6 : 11;
      beats = (len == 2'h0) ? 1 : (len == 2'h1) ? 4 : 8;
      req_write = wr;
      req_len = len;
      req_addr = bank_interleave_select ? (27'(r) << (cb + 2)) | (27'(b) << cb) | 27'(c)
        : (27'(b) << (cb + rb)) | (27'(r) << cb) | 27'(c);
      req_valid = 1'b1;
      n = 0;
      while (!req_ready && n < 50)
      begin
        @(negedge core_clk);
        n++;
      end
      if (n == 50)
        errors++;
      @(negedge core_clk);
      req_valid = 1'b0;
      `CHK({map_bank, map_row, map_col}, {b, r, c})
      `CHK(busy, 1'b1)
      for (int k = 0; k < beats; k++)
      begin
        // Count edges from the take edge, or from the previous beat's edge
        n = 1;
        if (k != 0)
          @(negedge core_clk);
        while (!beat_done && n < 40)
        begin
          @(negedge core_clk);
          n++;
        end
        `CHK(n, (k == 0) ? lat : 2)
        if (!wr)
          expq.push_back({4'(k), 2'h0, b, r, c});
      end
      pk = (len != 2'h0) ? 0 : wr ? 2 : 1;
      prev_b = b;
      prev_r = r;
      open_v[b] = 1'b1;
      open_row[b] = r;
    end
  endtask
  // Refresh closes every bank and holds requests off
  task automatic refresh;
    begin
      refresh_req = 1'b1;
      @(negedge core_clk);
      `CHK(req_ready, 1'b0)
      refresh_req = 1'b0;
      open_v = '{default: 1'b0};
      pk = 0;
      @(negedge core_clk);
    end
  endtask
  initial
  begin
    {rst_n, refresh_req, req_valid, req_write, stall} = 5'h0;
    {bank_interleave_select, row_sel, col_sel, req_len, req_addr} = '0;
    seed = 32'h796f;
    open_v = '{default: 1'b0};
    pk = 0;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    // Widest map: hand-picked corner pairs first
    {bank_interleave_select, row_sel, col_sel} = 5'h0b;
    access(1'b0, 2'h0, 2'h1, 13'h1fff, 11'h7ff);
    access(1'b1, 2'h0, 2'h1, 13'h1fff, 11'h001);
    access(1'b0, 2'h0, 2'h1, 13'h1fff, 11'h002);
    access(1'b0, 2'h0, 2'h1, 13'h0006, 11'h003);
    access(1'b1, 2'h2, 2'h2, 13'h0004, 11'h000);
    access(1'b1, 2'h1, 2'h2, 13'h0004, 11'h008);
    access(1'b1, 2'h1, 2'h2, 13'h0009, 11'h008);
    // Fill the FIFO with a stalled reader, then let it drain
    stall = 1'b1;
    access(1'b0, 2'h2, 2'h3, 13'h0001, 11'h000);
    repeat (4) @(negedge core_clk);
    `CHK(rd_valid, 1'b1)
    stall = 1'b0;
    // Every map setting, random traffic on few rows to mix hits and misses
    for (int cfg = 0; cfg < 32; cfg++)
    begin
      {bank_interleave_select, row_sel, col_sel} = 5'(cfg);
      refresh();
      repeat (6)
      begin
        tmp = $random(seed);
        access(tmp[0], (tmp[2:1] == 2'h3) ? 2'h0 : tmp[2:1], tmp[4:3], {12'h0, tmp[5]}, tmp[16:6]);
      end
    end
    complete_run();
  end
endmodule
`default_nettype wire
